// File: hw/fault_supervisor.sv
`timescale 1ns/100ps
// Operation
// - logic supply fail with enable set: fail-safe, registers to reset
// - fail-safe: channels follow direct inputs when power supply normal
// - without logic supply, faults still reach the fault pin
// - logic supply fail with enable clear: keep last configuration
// - power undervoltage with logic supply good: link stays operational
// - either supply rising alone past threshold sets power-on flag
// - wake transition with a supply already up sets power-on flag
// - power recovering while logic supply stayed up: no power-on reset
// - retry condition: overcurrent, short, overtemp or undervoltage
// - undervoltage and overtemp retries wait for cause to go
// - retry disabled: latchable fault latches channel off at once
// - retry enabled when enable bit equals channel load config
// - retry depends on config bits and remaining retry count
// - retry starts only with fault control high and condition true, or when unlimited is set on a latched channel
// - channel back on after retry period selected by two bits
// - fault gone early: fault pin high, count kept, fault bit kept
// - system ground loss: both off; load ground loss: open-load flag
// - device ground high: link lost and fail-safe entered
// - after fifteen retries full flag set, one more then latch
// - delatch may turn channel on, counter unchanged
// - unlimited retries never latch off
module fault_supervisor
  import supervisor_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       logic_supply_fail,
  input  wire logic       logic_supply_por,
  input  wire logic       power_supply_por,
  input  wire logic       power_uv,
  input  wire logic       supply_fail_en,
  input  wire logic       wake_reset_n,
  input  wire logic [1:0] direct_in,
  input  wire logic [1:0] spi_on,
  input  wire logic [1:0] channel_load_config,
  input  wire logic [7:0] retry_cfg,
  input  wire logic [1:0] fault_control,
  input  wire logic [1:0] overcurrent_flag,
  input  wire logic [1:0] severe_short_flag,
  input  wire logic [1:0] overtemp_flag,
  input  wire logic       undervoltage_flag,
  input  wire logic [1:0] diag_fault,
  input  wire logic [1:0] delatch,
  input  wire logic       system_gnd_loss,
  input  wire logic       load_gnd_loss,
  input  wire logic       device_gnd_high,
  input  wire logic       status_read,
  output logic [1:0]      hs_on,
  output logic            fault_flag_n,
  output logic            failsafe,
  output logic            spi_active,
  output logic [7:0]      status_reg,
  output logic [7:0]      retry_count,
  output logic [1:0]      fault_bit,
  output logic            open_load_flag,
  output logic [1:0]      retry_pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       fs;
    logic       vdd_por_prev;
    logic       vpwr_por_prev;
    logic       wake_prev;
    logic [7:0] stat;
    logic [1:0] fbit;
    logic       olf;
    logic [1:0] hs;
    logic       flag_n;
    logic       spi;
    logic [7:0] cnt;
    logic [1:0] pulse;
  } top_regs_t;

  top_regs_t s_q;
  top_regs_t s_d;

  logic [1:0] ch_enable;
  logic [1:0] ch_latched;
  logic [1:0] ch_full;
  logic [1:0] ch_pulse;
  logic [7:0] ch_cnt;
  logic [1:0] retry_cond;
  logic [1:0] latch_src;
  logic       clear_regs;
  logic       wake_now;
  logic [7:0] cfg_eff;

  // ----------------------------------------------------------------
  // retry channels
  // ----------------------------------------------------------------
  // a fail-safe entry wipes configuration back to reset values
  // built from the inputs, not from s_d, so no loop through the state
  assign clear_regs = (device_gnd_high |
                       (logic_supply_fail & supply_fail_en)) & ~s_q.fs;
  assign cfg_eff    = s_q.fs ? {RETRY_CFG_RESET, RETRY_CFG_RESET}
                             : retry_cfg;
  assign retry_cond = overcurrent_flag | severe_short_flag |
                      overtemp_flag | {2{undervoltage_flag}};
  assign latch_src  = overtemp_flag | {2{undervoltage_flag}};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      retry_channel u_ch (
        .clock         (clock),
        .rst_n         (rst_n),
        .clear         (clear_regs),
        .load_config   (channel_load_config[g]),
        .retry_cfg     (cfg_eff[4*g +: 4]),
        .fault_control (fault_control[g]),
        .retry_cond    (retry_cond[g]),
        .cause_slow    (latch_src[g]),
        .delatch       (delatch[g]),
        .ch_enable     (ch_enable[g]),
        .latched       (ch_latched[g]),
        .retry_count   (ch_cnt[4*g +: 4]),
        .retry_full    (ch_full[g]),
        .retry_pulse   (ch_pulse[g])
      );
    end
  endgenerate

  assign wake_now = wake_reset_n | (|direct_in);

  // ----------------------------------------------------------------
  // supervision
  // ----------------------------------------------------------------
  always_comb begin
    s_d               = s_q;
    s_d.vdd_por_prev  = logic_supply_por;
    s_d.vpwr_por_prev = power_supply_por;
    s_d.wake_prev     = wake_now;
    s_d.pulse         = ch_pulse;
    s_d.cnt           = ch_cnt;
    // fail-safe on logic supply loss only if the enable is set in the same cycle
    if (logic_supply_fail && supply_fail_en) begin
      s_d.fs = 1'b1;
    end else if (!logic_supply_fail && !device_gnd_high) begin
      s_d.fs = 1'b0;
    end
    if (device_gnd_high) begin
      s_d.fs = 1'b1;
    end
    // link stays up under power undervoltage; lost on ground lift
    s_d.spi = ~device_gnd_high & ~logic_supply_fail;
    // power-on flag: one supply rising while the other is down
    if ((power_supply_por && !s_q.vpwr_por_prev && !logic_supply_por &&
         !s_q.vdd_por_prev) ||
        (logic_supply_por && !s_q.vdd_por_prev && !power_supply_por &&
         !s_q.vpwr_por_prev)) begin
      s_d.stat[STAT_POR_BIT] = 1'b1;
    end else if (status_read) begin
      s_d.stat[STAT_POR_BIT] = 1'b0;
    end
    if (wake_now && !s_q.wake_prev &&
        (s_q.vpwr_por_prev || s_q.vdd_por_prev)) begin
      s_d.stat[STAT_POR_BIT] = 1'b1;
    end
    s_d.stat[STAT_RFULL0_BIT] = ch_full[0];
    s_d.stat[STAT_RFULL1_BIT] = ch_full[1];
    // fault bit is sticky; set wins over the read clear
    if (status_read && !(|retry_cond)) begin
      s_d.fbit = 2'b00;
    end
    s_d.fbit = s_d.fbit | (retry_cond & fault_control);
    if (load_gnd_loss) begin
      s_d.olf = 1'b1;
    end else if (status_read) begin
      s_d.olf = 1'b0;
    end
    // channel drive
    if (s_d.fs) begin
      s_d.hs = power_uv ? 2'b00 : direct_in;
    end else begin
      s_d.hs = spi_on & ch_enable;
    end
    s_d.hs = s_d.hs & ch_enable;
    if (system_gnd_loss) begin
      s_d.hs = 2'b00;
    end
    // fault pin reports live faults whatever the logic supply does
    s_d.flag_n = ~(|((retry_cond & fault_control) | ch_latched |
                    diag_fault) | load_gnd_loss);
    if (clear_regs) begin
      s_d.fbit = 2'b00;
      s_d.stat = STATUS_RESET;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q.fs            <= 1'b0;
      s_q.vdd_por_prev  <= 1'b0;
      s_q.vpwr_por_prev <= 1'b0;
      // idle level of the wake pin, so release gives no false wake edge
      s_q.wake_prev     <= 1'b1;
      s_q.stat          <= STATUS_RESET;
      s_q.fbit          <= 2'b00;
      s_q.olf           <= 1'b0;
      s_q.hs            <= 2'b00;
      s_q.flag_n        <= 1'b1;
      s_q.spi           <= 1'b0;
      s_q.cnt           <= 8'h00;
      s_q.pulse         <= 2'b00;
    end else begin
      s_q <= s_d;
    end
  end

  assign hs_on          = s_q.hs;
  assign fault_flag_n   = s_q.flag_n;
  assign failsafe       = s_q.fs;
  assign spi_active     = s_q.spi;
  assign status_reg     = s_q.stat;
  assign retry_count    = s_q.cnt;
  assign fault_bit      = s_q.fbit;
  assign open_load_flag = s_q.olf;
  assign retry_pulse    = s_q.pulse;

endmodule // fault_supervisor

// File: hw/retry_channel.sv
`timescale 1ns/100ps
module retry_channel
  import supervisor_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       load_config,
  input  wire logic [3:0] retry_cfg,
  input  wire logic       fault_control,
  input  wire logic       retry_cond,
  input  wire logic       cause_slow,
  input  wire logic       delatch,
  output logic            ch_enable,
  output logic            latched,
  output logic [3:0]      retry_count,
  output logic            retry_full,
  output logic            retry_pulse
);

  typedef struct packed {
    ch_state_t   st;
    logic [15:0] timer;
    logic [3:0]  cnt;
    logic        full;
    logic        used;
    logic        pulse;
    logic        en_prev;
    logic        unl_prev;
  } ch_regs_t;

  ch_regs_t r_q;
  ch_regs_t r_d;
  logic     retry_en;
  logic     fault_now;

  function automatic logic [15:0] period_cycles(input logic [1:0] sel);
    unique case (sel)
      2'b00:   period_cycles = RETRY_P0_CYC;
      2'b01:   period_cycles = RETRY_P1_CYC;
      2'b10:   period_cycles = RETRY_P2_CYC;
      default: period_cycles = RETRY_P3_CYC;
    endcase
  endfunction

  assign retry_en  = (retry_cfg[RETRY_EN_BIT] == load_config);
  assign fault_now = fault_control & retry_cond;

  always_comb begin
    r_d          = r_q;
    r_d.pulse    = 1'b0;
    r_d.en_prev  = retry_en;
    r_d.unl_prev = retry_cfg[RETRY_UNLIM_BIT];
    unique case (r_q.st)
      CH_ON: begin
        if (fault_now) begin
          if (!retry_en) begin
            r_d.st = CH_LATCHED;
          end else if (!r_q.used || retry_cfg[RETRY_UNLIM_BIT]) begin
            r_d.st = cause_slow ? CH_WAIT : CH_TIMING;
            r_d.timer = period_cycles(retry_cfg[3:2]);
          end else begin
            r_d.st = CH_LATCHED;
          end
        end
      end
      CH_WAIT: begin
        // undervoltage or overtemperature: hold off until cause gone
        if (!cause_slow) begin
          r_d.st = CH_TIMING;
        end
      end
      CH_TIMING: begin
        if (r_q.timer <= TIMER_ONE) begin
          r_d.st    = CH_ON;
          r_d.pulse = 1'b1;
          if (!retry_cfg[RETRY_UNLIM_BIT]) begin
            // full already set: this was the one extra retry allowed
            if (r_q.full) begin
              r_d.used = 1'b1;
            end
            if (r_q.cnt == RETRY_CNT_FULL - 4'h1) begin
              r_d.full = 1'b1;
            end
            if (r_q.cnt != RETRY_CNT_FULL) begin
              r_d.cnt = r_q.cnt + 4'h1;
            end
          end
        end else begin
          r_d.timer = r_q.timer - TIMER_ONE;
        end
      end
      CH_LATCHED: begin
      end
    endcase
    // delatch turns channel on but leaves the counter alone
    if (delatch && r_q.st != CH_ON) begin
      r_d.st = CH_ON;
    end
    // switching to unlimited or disabling resets the counter
    if ((retry_cfg[RETRY_UNLIM_BIT] && !r_q.unl_prev) ||
        (!retry_en && r_q.en_prev)) begin
      r_d.cnt  = RETRY_CNT_RESET;
      r_d.full = 1'b0;
      r_d.used = 1'b0;
      if (r_q.st == CH_LATCHED && retry_en) begin
        r_d.st    = CH_TIMING;
        r_d.timer = period_cycles(retry_cfg[3:2]);
      end
    end
    if (retry_cfg[RETRY_UNLIM_BIT] && r_q.st == CH_LATCHED &&
        retry_en) begin
      r_d.st = CH_TIMING;
      r_d.timer = period_cycles(retry_cfg[3:2]);
    end
    if (clear) begin
      r_d.st   = CH_ON;
      r_d.cnt  = RETRY_CNT_RESET;
      r_d.full = 1'b0;
      r_d.used = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r_q.st       <= CH_ON;
      r_q.timer    <= TIMER_ZERO;
      r_q.cnt      <= RETRY_CNT_RESET;
      r_q.full     <= 1'b0;
      r_q.used     <= 1'b0;
      r_q.pulse    <= 1'b0;
      r_q.en_prev  <= 1'b0;
      r_q.unl_prev <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  assign ch_enable   = (r_q.st == CH_ON);
  assign latched     = (r_q.st == CH_LATCHED);
  assign retry_count = r_q.cnt;
  assign retry_full  = r_q.full;
  assign retry_pulse = r_q.pulse;

endmodule // retry_channel

// File: hw/supervisor_pkg.sv
package supervisor_pkg;

  // ----------------------------------------------------------------
  // retry configuration field positions (per channel, 4 bits)
  // ----------------------------------------------------------------
  localparam int unsigned RETRY_EN_BIT     = 0;
  localparam int unsigned RETRY_UNLIM_BIT  = 1;
  localparam int unsigned RETRY_PER_LO_BIT = 2;
  localparam int unsigned RETRY_PER_HI_BIT = 3;
  localparam logic [3:0]  RETRY_CFG_RESET  = 4'h0;

  // ----------------------------------------------------------------
  // retry counter
  // ----------------------------------------------------------------
  localparam logic [3:0] RETRY_CNT_RESET = 4'h0;
  localparam logic [3:0] RETRY_CNT_FULL  = 4'hf;

  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------
  localparam int unsigned STAT_RFULL0_BIT = 4;
  localparam int unsigned STAT_RFULL1_BIT = 5;
  localparam int unsigned STAT_POR_BIT    = 6;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // timing: clock rate and retry periods
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_HZ      = 25_000_000;
  localparam int unsigned RETRY_P0_US   = 8;
  localparam int unsigned RETRY_P1_US   = 16;
  localparam int unsigned RETRY_P2_US   = 32;
  localparam int unsigned RETRY_P3_US   = 64;
  localparam int unsigned CYC_PER_US    = CLOCK_HZ / 1_000_000;
  localparam logic [15:0] RETRY_P0_CYC  = 16'(RETRY_P0_US * CYC_PER_US);
  localparam logic [15:0] RETRY_P1_CYC  = 16'(RETRY_P1_US * CYC_PER_US);
  localparam logic [15:0] RETRY_P2_CYC  = 16'(RETRY_P2_US * CYC_PER_US);
  localparam logic [15:0] RETRY_P3_CYC  = 16'(RETRY_P3_US * CYC_PER_US);
  localparam logic [15:0] TIMER_ZERO    = 16'h0000;
  localparam logic [15:0] TIMER_ONE     = 16'h0001;

  typedef enum logic [3:0] {
    CH_ON      = 4'b0001,
    CH_WAIT    = 4'b0010,
    CH_TIMING  = 4'b0100,
    CH_LATCHED = 4'b1000
  } ch_state_t;

endpackage

// File: verification/supervisor_asserts.sv
`timescale 1ns/100ps
module supervisor_asserts
  import supervisor_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       logic_supply_fail,
  input wire logic       logic_supply_por,
  input wire logic       power_supply_por,
  input wire logic       supply_fail_en,
  input wire logic       wake_reset_n,
  input wire logic [1:0] channel_load_config,
  input wire logic [7:0] retry_cfg,
  input wire logic [1:0] fault_control,
  input wire logic [1:0] overcurrent_flag,
  input wire logic [1:0] severe_short_flag,
  input wire logic       system_gnd_loss,
  input wire logic       device_gnd_high,
  input wire logic       status_read,
  input wire logic [1:0] hs_on,
  input wire logic       fault_flag_n,
  input wire logic       failsafe,
  input wire logic       spi_active,
  input wire logic [7:0] status_reg,
  input wire logic [1:0] fault_bit,
  input wire logic [1:0] retry_pulse
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_failsafe_entry: assert property (
    $past(supply_fail_en) && logic_supply_fail |-> ##[1:2] failsafe)
    else $error("fail-safe not entered");
  chk_gnd_high: assert property (
    device_gnd_high |-> ##[1:2] (failsafe && !spi_active))
    else $error("ground high not handled");
  chk_short_off: assert property (
    fault_control[1] && severe_short_flag[1]
    |-> ##[1:2] (!hs_on[1] && !fault_flag_n)) else $error("short kept on");
  // mismatched enable bit means no retry, so the channel must drop
  chk_latch_off: assert property (
    overcurrent_flag[0] && fault_control[0] && !failsafe &&
    (retry_cfg[RETRY_EN_BIT] != channel_load_config[0])
    |-> ##[1:2] !hs_on[0]) else $error("fault not latched");
  chk_system_gnd: assert property (
    system_gnd_loss |-> ##[1:2] (hs_on == 2'b00))
    else $error("channels on after ground loss");
  chk_pulse_width: assert property (
    retry_pulse[0] |=> !retry_pulse[0]) else $error("retry pulse too long");
  chk_wake_por: assert property (
    $rose(wake_reset_n) && power_supply_por && $past(power_supply_por)
    |-> ##[1:3] status_reg[STAT_POR_BIT]) else $error("wake flag missed");
  chk_por_rise: assert property (
    $rose(power_supply_por) && !logic_supply_por &&
    !$past(logic_supply_por) |-> ##[1:3] status_reg[STAT_POR_BIT])
    else $error("supply flag missed");
  // sticky fault bit only goes on a read, fail-safe or wake
  chk_sticky_fault: assert property (
    $fell(fault_bit[0]) |-> $past(status_read) || failsafe ||
    !$past(wake_reset_n)) else $error("fault bit lost");
endmodule // supervisor_asserts

// File: verification/tb_fault_supervisor.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected %0t %h %h", $time, (a), (e)); end end
module tb_fault_supervisor;
  import supervisor_pkg::*;
  logic       clock, rst_n, logic_supply_fail, logic_supply_por;
  logic       power_supply_por, power_uv, supply_fail_en, wake_reset_n;
  logic       undervoltage_flag, system_gnd_loss, load_gnd_loss;
  logic       device_gnd_high, status_read, fault_flag_n, failsafe;
  logic       spi_active, open_load_flag;
  logic [1:0] direct_in, spi_on, channel_load_config, fault_control;
  logic [1:0] overcurrent_flag, severe_short_flag, overtemp_flag;
  logic [1:0] diag_fault, delatch, hs_on, fault_bit, retry_pulse;
  logic [7:0] retry_cfg, status_reg, retry_count;
  int         mismatches, checked, cycles, n, p;
  int         per0 = int'(RETRY_P0_CYC);

  fault_supervisor DUT (.*);
  wake_ctrl_model partner (.clock(clock), .power_uv(power_uv),
                           .wake_reset_n(wake_reset_n));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // run ceiling well above the longest expected sequence
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      results();
    end
  end

  task automatic results;
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic rd;
    status_read = 1'b1;
    tick(1);
    status_read = 1'b0;
    tick(2);
  endtask
  task automatic dl;
    delatch[0] = 1'b1;
    tick(1);
    delatch[0] = 1'b0;
    tick(3);
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    tick(6);
    `CHK(fault_flag_n, 1'b1)
    rst_n = 1'b1;
    tick(2);
    rd();
  endtask
  task automatic pulse_wait(input int ch);
    n = 0;
    while (retry_pulse[ch] !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic pulses(input int ch, input int k);
    p = 0;
    repeat (k) begin
      tick(1);
      if (retry_pulse[ch] === 1'b1) p++;
    end
  endtask
  task automatic in_window(input int per);
    `CHK(n >= per - 4 && n <= per + 6, 1'b1)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_retry;
    spi_on = 2'b11;
    overcurrent_flag[0] = 1'b1;
    tick(3);
    `CHK(hs_on[0], 1'b0)
    overcurrent_flag[0] = 1'b0;
    pulse_wait(0);
    in_window(per0);
    tick(4);
    `CHK(hs_on[0], 1'b1)
    `CHK(fault_flag_n, 1'b1)
    `CHK(fault_bit[0], 1'b1)
    `CHK(retry_count[3:0], 4'h1)
    rd();
    `CHK(fault_bit[0], 1'b0)
    `CHK(retry_count[3:0], 4'h1)
  endtask

  task automatic t_periods;
    channel_load_config = 2'b10;
    for (int k = 0; k < 4; k++) begin
      retry_cfg[7:4] = {k[1:0], 2'b01};
      tick(2);
      severe_short_flag[1] = 1'b1;
      tick(3);
      severe_short_flag[1] = 1'b0;
      pulse_wait(1);
      in_window(per0 << k);
      tick(4);
    end
    `CHK(retry_count[7:4], 4'h4)
  endtask

  task automatic t_wait;
    overtemp_flag[0] = 1'b1;
    undervoltage_flag = 1'b1;
    pulses(0, 300);
    `CHK(p, 0)
    overtemp_flag[0] = 1'b0;
    pulses(0, 300);
    `CHK(p, 0)
    undervoltage_flag = 1'b0;
    pulse_wait(0);
    in_window(per0);
  endtask

  task automatic t_off;
    fault_control[0] = 1'b0;
    overcurrent_flag[0] = 1'b1;
    tick(3);
    overcurrent_flag[0] = 1'b0;
    pulses(0, 400);
    `CHK(p, 0)
    fault_control[0] = 1'b1;
    dl();
    retry_cfg[3:0] = 4'h1;
    tick(2);
    overcurrent_flag[0] = 1'b1;
    tick(3);
    overcurrent_flag[0] = 1'b0;
    pulses(0, 400);
    `CHK(p, 0)
    `CHK(hs_on[0], 1'b0)
    dl();
    `CHK(hs_on[0], 1'b1)
    retry_cfg[3:0] = 4'h0;
  endtask

  task automatic t_latch;
    do_reset();
    overcurrent_flag[0] = 1'b1;
    pulses(0, 17 * (per0 + 10));
    `CHK(p, 16)
    `CHK(status_reg[STAT_RFULL0_BIT], 1'b1)
    `CHK(retry_count[3:0], RETRY_CNT_FULL)
    `CHK(fault_flag_n, 1'b0)
    overcurrent_flag[0] = 1'b0;
    dl();
    `CHK(hs_on[0], 1'b1)
    `CHK(retry_count[3:0], RETRY_CNT_FULL)
    overcurrent_flag[0] = 1'b1;
    retry_cfg[RETRY_UNLIM_BIT] = 1'b1;
    pulses(0, 18 * (per0 + 10));
    `CHK(p >= 17, 1'b1)
    overcurrent_flag[0] = 1'b0;
    retry_cfg[RETRY_UNLIM_BIT] = 1'b0;
    tick(250);
  endtask

  task automatic t_fail;
    supply_fail_en = 1'b1;
    tick(1);
    logic_supply_fail = 1'b1;
    direct_in = 2'b01;
    spi_on = 2'b10;
    tick(4);
    `CHK(failsafe, 1'b1)
    `CHK(retry_count, 8'h00)
    `CHK(hs_on, 2'b01)
    diag_fault[1] = 1'b1;
    tick(3);
    `CHK(fault_flag_n, 1'b0)
    diag_fault[1] = 1'b0;
    supply_fail_en = 1'b0;
    logic_supply_fail = 1'b0;
    direct_in = 2'b00;
    tick(3);
    logic_supply_fail = 1'b1;
    spi_on = 2'b11;
    tick(3);
    `CHK(failsafe, 1'b0)
    `CHK(hs_on, 2'b11)
    logic_supply_fail = 1'b0;
  endtask

  task automatic t_sup;
    rd();
    power_uv = 1'b1;
    tick(3);
    `CHK(spi_active, 1'b1)
    power_uv = 1'b0;
    tick(10);
    `CHK(status_reg[STAT_POR_BIT], 1'b1)
    system_gnd_loss = 1'b1;
    tick(3);
    `CHK(hs_on, 2'b00)
    system_gnd_loss = 1'b0;
    load_gnd_loss = 1'b1;
    tick(3);
    `CHK(open_load_flag, 1'b1)
    load_gnd_loss = 1'b0;
    device_gnd_high = 1'b1;
    tick(3);
    `CHK(spi_active, 1'b0)
    device_gnd_high = 1'b0;
    tick(3);
  endtask

  task automatic t_por;
    rd();
    power_supply_por = 1'b0;
    tick(3);
    power_supply_por = 1'b1;
    tick(4);
    `CHK(status_reg[STAT_POR_BIT], 1'b0)
    logic_supply_por = 1'b0;
    power_supply_por = 1'b0;
    tick(3);
    power_supply_por = 1'b1;
    tick(4);
    `CHK(status_reg[STAT_POR_BIT], 1'b1)
    logic_supply_por = 1'b1;
  endtask

  initial begin
    {logic_supply_fail, power_uv, supply_fail_en, undervoltage_flag} = '0;
    {system_gnd_loss, load_gnd_loss, device_gnd_high, status_read} = '0;
    {logic_supply_por, power_supply_por} = 2'b11;
    {direct_in, spi_on, channel_load_config, overcurrent_flag} = '0;
    {severe_short_flag, overtemp_flag, diag_fault, delatch} = '0;
    fault_control = 2'b11;
    retry_cfg = 8'h00;
    do_reset();
    t_retry();
    t_periods();
    t_wait();
    t_off();
    t_latch();
    t_fail();
    t_sup();
    t_por();
    results();
  end
endmodule // tb_fault_supervisor

bind fault_supervisor supervisor_asserts chk (.*);

// File: verification/wake_ctrl_model.sv
`timescale 1ns/100ps
module wake_ctrl_model (
  input  wire logic clock,
  input  wire logic power_uv,
  output logic      wake_reset_n
);
  // ----------------------------------------------------------------
  // controller side of the wake pin
  // ----------------------------------------------------------------
  logic       uv_q;
  logic [1:0] hold_q;

  initial begin
    uv_q = 1'b0;
    hold_q = 2'b00;
    wake_reset_n = 1'b1;
  end

  // pin held high through undervoltage keeps the chain alive
  always @(posedge clock) begin
    uv_q <= power_uv;
    if (uv_q && !power_uv) begin
      hold_q <= 2'b10;
    end else if (hold_q != 2'b00) begin
      hold_q <= hold_q - 2'b01;
    end
    wake_reset_n <= power_uv || (hold_q == 2'b00);
  end
endmodule // wake_ctrl_model
